// >>> pkg/cell_sel_pkg.sv
/*
  Package for the logic cell input selection stage: register word
  indices, field positions, reset values, sizes and carriers.
  Assumes one 50 MHz clock and a word-addressed register bus.
*/
package cell_sel_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CELL_COUNT   = 4;   // Cells in the stage
  localparam int GATE_COUNT   = 4;   // Gates per cell
  localparam int SRC_COUNT    = 4;   // Data sources per cell
  localparam int SEL_W        = 3;   // Width of one select field
  localparam int ADDR_W       = 4;   // Word address width
  localparam int DATA_W       = 32;  // Bus data width

  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_IDX_BASE = 4'h0; // Mux select, cell 1
  localparam logic [3:0] GLS_IDX_BASE = 4'h1; // Gate enables, cell 1
  localparam logic [3:0] IDX_STRIDE   = 4'h2; // Words per cell

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC1_LSB     = 0;   // Source 1 select, bits 2-0
  localparam int SRC3_LSB     = 8;   // Source 3 select, bits 10-8
  localparam int GATE_BYTE_W  = 8;   // One byte per gate
  localparam int TRUE_OFS     = 1;   // True enable within a pair
  localparam int INV_OFS      = 0;   // Inverted enable within a pair

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_RESET = 3'h0;        // Pin input B
  localparam logic [31:0] GLS_RESET = 32'h00000000; // All withheld

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES  = 2;   // Flops in a synchroniser

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Event and pin inputs, asynchronous to the clock
  typedef struct packed {
    logic [3:0] cell_pin_input_b;     // Input B pin per cell
    logic       comparator_one;       // Comparator 1 output
    logic       comparator_three;     // Comparator 3 output
    logic [2:0] uart_tx;              // Serial ports 1..3 transmit
    logic [2:0] serial_data_in;       // Serial peripherals 1..3 in
    logic       adc_done;             // ADC conversion done
    logic [1:0] dma_irq;              // DMA channels 0..1
    logic [2:0] multi_compare_match;  // Multi compare units 1..3
    logic       single_compare5_match; // Single compare 5 match
    logic       single_compare7_match; // Single compare 7 match
    logic [3:0] single_compare_out;   // Units 5, 6, 7A, 3A outputs
    logic       real_time_clock_event; // Real-time-clock event
  } periph_in_t;

  // Gate terms: per cell one word laid out as the enable register
  typedef logic [CELL_COUNT-1:0][DATA_W-1:0] gate_terms_t;

  // Selected sources 1 and 3, per cell
  typedef struct packed {
    logic [CELL_COUNT-1:0] src1;
    logic [CELL_COUNT-1:0] src3;
  } selected_t;

endpackage

// >>> logic/bit_sync.sv
/*
  Two-flop synchroniser bank of parameterised width.
  Assumes inputs are levels that stay put for at least two clocks.
*/
`timescale 1ns/100ps
module bit_sync
  import cell_sel_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;  // Only read by stage2
    logic [WIDTH-1:0] stage2;  // Safe to use
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // Shift the inputs through two stages
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.stage1 = async_in;
    nxt_state.stage2 = state_ff.stage1;
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stage2;

endmodule // bit_sync

// >>> logic/cell_source_mux.sv
/*
  Eight-way source selector for one data source of one cell.
  Assumes the caller ties reserved candidates to zero.
*/
`timescale 1ns/100ps
module cell_source_mux
  import cell_sel_pkg::*;
(
  input  wire logic [7:0]       cand,
  input  wire logic [SEL_W-1:0] code,
  output logic                  picked
);

  // Pick the candidate named by the code
  always_comb begin
    picked = cand[code];
  end

endmodule // cell_source_mux

// >>> logic/cell_input_select.sv
/*
  Input selection stage of four configurable logic cells: source 1
  and source 3 multiplexers, and the gate source enable matrix, set
  up by software over an Avalon-MM slave with waitrequest.
  Assumes one clock, synchronous active-high reset, event inputs
  asynchronous, source 2 and 4 inputs and cell outputs synchronous.
*/
// Design decisions made here: the Avalon-MM register port and the address map.
// Behaviour
// [RULE_01] Cell 1 source 3 codes route listed sources
// [RULE_02] Cell 2 source 3 codes route listed sources
// [RULE_03] Cell 3 source 3 codes; 111 reserved
// [RULE_04] Cell 4 source 3; 011, 111 reserved
// [RULE_05] Cell 1 source 1 codes route listed sources
// [RULE_06] Cell 2 source 1 codes route listed sources
// [RULE_07] Cell 3 source 1 codes route listed sources
// [RULE_08] Cell 4 source 1; code 011 reserved
// [RULE_09] One enable byte per gate, source 4 first
// [RULE_10] True enable passes the uninverted source
// [RULE_11] Negated enable passes the inverted source
// [RULE_12] Unimplemented select bits ignore writes, read zero
// [RULE_13] Synchronise sources; reserved codes give low
`timescale 1ns/100ps
module cell_input_select
  import cell_sel_pkg::*;
#(
  parameter int CELLS = CELL_COUNT
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]     address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [DATA_W-1:0]     writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [DATA_W-1:0]     readdata,
  output logic                       waitrequest,
  // Sources
  input  wire periph_in_t            periph_in,
  input  wire logic [CELL_COUNT-1:0] cell_out,
  input  wire logic [CELL_COUNT-1:0] source2_in,
  input  wire logic [CELL_COUNT-1:0] source4_in,
  // Results
  output gate_terms_t                gate_terms,
  output selected_t                  selected
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (CELLS != CELL_COUNT) begin : g_bad_cells
      $error("cell_input_select serves exactly four cells");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CELL_COUNT-1:0][SEL_W-1:0]  src1_sel; // source1_select
    logic [CELL_COUNT-1:0][SEL_W-1:0]  src3_sel; // source3_select
    logic [CELL_COUNT-1:0][DATA_W-1:0] gls;      // Gate enables
    logic                              ack;      // Answer cycle
    logic [DATA_W-1:0]                 rdata;    // Read data
    gate_terms_t                       terms;    // Gated sources
    selected_t                         sel_out;  // Chosen sources
  } sel_state_t;

  sel_state_t state_ff;   // Registered state
  sel_state_t nxt_state;  // Next state

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  periph_in_t ev_sync;                       // Synchronised events
  logic [$bits(periph_in_t)-1:0] ev_raw;     // Flat view of events
  logic [$bits(periph_in_t)-1:0] ev_flat;    // Flat synchronised

  assign ev_raw  = periph_in;
  assign ev_sync = periph_in_t'(ev_flat);

  // Events cross into the clock domain before any mux  [RULE_13]
  bit_sync #(
    .WIDTH    ($bits(periph_in_t))
  ) u_ev_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in (ev_raw),
    .sync_out (ev_flat)
  );

  // ----------------------------------------------------------------
  // Candidate tables
  // ----------------------------------------------------------------
  logic [CELL_COUNT-1:0][7:0] cand1;  // Source 1 candidates
  logic [CELL_COUNT-1:0][7:0] cand3;  // Source 3 candidates
  logic [CELL_COUNT-1:0]      pick1;  // Chosen source 1
  logic [CELL_COUNT-1:0]      pick3;  // Chosen source 3

  // Build the per-cell candidate lists, reserved entries low
  always_comb begin
    cand1 = '0;
    cand3 = '0;
    // Cell 1, source 3
    cand3[0][0] = ev_sync.cell_pin_input_b[0];      // [RULE_01]
    cand3[0][1] = cell_out[1];                      // [RULE_01]
    cand3[0][2] = ev_sync.comparator_one;           // [RULE_01]
    cand3[0][3] = ev_sync.uart_tx[0];               // [RULE_01]
    cand3[0][4] = ev_sync.adc_done;                 // [RULE_01]
    cand3[0][5] = ev_sync.dma_irq[0];               // [RULE_01]
    cand3[0][6] = ev_sync.multi_compare_match[0];   // [RULE_01]
    cand3[0][7] = 1'b0;                             // [RULE_13]
    // Cell 2, source 3
    cand3[1][0] = ev_sync.cell_pin_input_b[1];      // [RULE_02]
    cand3[1][1] = cell_out[0];                      // [RULE_02]
    cand3[1][2] = ev_sync.comparator_one;           // [RULE_02]
    cand3[1][3] = ev_sync.uart_tx[1];               // [RULE_02]
    cand3[1][4] = ev_sync.adc_done;                 // [RULE_02]
    cand3[1][5] = ev_sync.dma_irq[1];               // [RULE_02]
    cand3[1][6] = ev_sync.multi_compare_match[0];   // [RULE_02]
    cand3[1][7] = 1'b0;                             // [RULE_13]
    // Cell 3, source 3
    cand3[2][0] = ev_sync.cell_pin_input_b[2];      // [RULE_03]
    cand3[2][1] = cell_out[3];                      // [RULE_03]
    cand3[2][2] = ev_sync.comparator_one;           // [RULE_03]
    cand3[2][3] = ev_sync.uart_tx[2];               // [RULE_03]
    cand3[2][4] = ev_sync.adc_done;                 // [RULE_03]
    cand3[2][5] = ev_sync.dma_irq[0];               // [RULE_03]
    cand3[2][6] = ev_sync.multi_compare_match[1];   // [RULE_03]
    cand3[2][7] = 1'b0;                             // [RULE_13]
    // Cell 4, source 3
    cand3[3][0] = ev_sync.cell_pin_input_b[3];      // [RULE_04]
    cand3[3][1] = cell_out[2];                      // [RULE_04]
    cand3[3][2] = ev_sync.comparator_one;           // [RULE_04]
    cand3[3][3] = 1'b0;                             // [RULE_13]
    cand3[3][4] = ev_sync.adc_done;                 // [RULE_04]
    cand3[3][5] = ev_sync.dma_irq[1];               // [RULE_04]
    cand3[3][6] = ev_sync.multi_compare_match[2];   // [RULE_04]
    cand3[3][7] = 1'b0;                             // [RULE_13]
    // Cell 1, source 1
    cand1[0][0] = ev_sync.cell_pin_input_b[0];      // [RULE_05]
    cand1[0][1] = cell_out[1];                      // [RULE_05]
    cand1[0][2] = ev_sync.single_compare_out[0];    // [RULE_05]
    cand1[0][3] = ev_sync.serial_data_in[0];        // [RULE_05]
    cand1[0][4] = ev_sync.comparator_three;         // [RULE_05]
    cand1[0][5] = ev_sync.real_time_clock_event;    // [RULE_05]
    cand1[0][6] = ev_sync.multi_compare_match[0];   // [RULE_05]
    cand1[0][7] = ev_sync.single_compare5_match;    // [RULE_05]
    // Cell 2, source 1
    cand1[1][0] = ev_sync.cell_pin_input_b[1];      // [RULE_06]
    cand1[1][1] = cell_out[0];                      // [RULE_06]
    cand1[1][2] = ev_sync.single_compare_out[1];    // [RULE_06]
    cand1[1][3] = ev_sync.serial_data_in[1];        // [RULE_06]
    cand1[1][4] = ev_sync.comparator_three;         // [RULE_06]
    cand1[1][5] = ev_sync.real_time_clock_event;    // [RULE_06]
    cand1[1][6] = ev_sync.multi_compare_match[0];   // [RULE_06]
    cand1[1][7] = ev_sync.single_compare5_match;    // [RULE_06]
    // Cell 3, source 1
    cand1[2][0] = ev_sync.cell_pin_input_b[2];      // [RULE_07]
    cand1[2][1] = cell_out[3];                      // [RULE_07]
    cand1[2][2] = ev_sync.single_compare_out[2];    // [RULE_07]
    cand1[2][3] = ev_sync.serial_data_in[2];        // [RULE_07]
    cand1[2][4] = ev_sync.comparator_three;         // [RULE_07]
    cand1[2][5] = ev_sync.real_time_clock_event;    // [RULE_07]
    cand1[2][6] = ev_sync.multi_compare_match[1];   // [RULE_07]
    cand1[2][7] = ev_sync.single_compare7_match;    // [RULE_07]
    // Cell 4, source 1
    cand1[3][0] = ev_sync.cell_pin_input_b[3];      // [RULE_08]
    cand1[3][1] = cell_out[2];                      // [RULE_08]
    cand1[3][2] = ev_sync.single_compare_out[3];    // [RULE_08]
    cand1[3][3] = 1'b0;                             // [RULE_13]
    cand1[3][4] = ev_sync.comparator_three;         // [RULE_08]
    cand1[3][5] = ev_sync.real_time_clock_event;    // [RULE_08]
    cand1[3][6] = ev_sync.multi_compare_match[2];   // [RULE_08]
    cand1[3][7] = ev_sync.single_compare7_match;    // [RULE_08]
  end

  // ----------------------------------------------------------------
  // Multiplexers, one pair per cell
  // ----------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < CELL_COUNT; gc++) begin : g_cell
      // Source 1 chosen by source1_select
      cell_source_mux u_mux1 (
        .cand   (cand1[gc]),
        .code   (state_ff.src1_sel[gc]),
        .picked (pick1[gc])
      );
      // Source 3 chosen by source3_select
      cell_source_mux u_mux3 (
        .cand   (cand3[gc]),
        .code   (state_ff.src3_sel[gc]),
        .picked (pick3[gc])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic                  req;      // Any bus request
  logic [ADDR_W-1:0]     rel_idx;  // Index from base
  logic [1:0]            hit_cell; // Addressed cell
  logic                  hit_gls;  // Gate enable word
  logic                  mapped;   // Address is ours
  logic [DATA_W-1:0]     rd_val;   // Word to return
  logic [DATA_W-1:0]     be_mask;  // Byte lane mask

  // Decode address into cell and word kind
  always_comb begin
    req      = read | write;
    rel_idx  = address - SEL_IDX_BASE;
    hit_cell = rel_idx[2:1];
    hit_gls  = rel_idx[0];
    mapped   = (rel_idx < (IDX_STRIDE * 4'(CELL_COUNT)));
    be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                {8{byteenable[1]}}, {8{byteenable[0]}}};
    rd_val   = '0;
    if (mapped && hit_gls) begin
      rd_val = state_ff.gls[hit_cell];
    end else if (mapped) begin
      // Only the two select fields read back  [RULE_12]
      rd_val[SRC1_LSB +: SEL_W] = state_ff.src1_sel[hit_cell];
      rd_val[SRC3_LSB +: SEL_W] = state_ff.src3_sel[hit_cell];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] gls_new;  // Merged gate enable word
  logic [DATA_W-1:0] src_t;    // Source pairs, true and inverted

  // Bus answer, register writes and the gate matrix
  always_comb begin
    nxt_state = state_ff;
    gls_new   = '0;
    src_t     = '0;
    // First request cycle: capture read data, answer next cycle
    if (req && !state_ff.ack) begin
      nxt_state.ack   = 1'b1;
      nxt_state.rdata = rd_val;
    end else begin
      nxt_state.ack   = 1'b0;
    end
    // Writes land on the answer edge only
    if (write && state_ff.ack && mapped) begin
      if (hit_gls) begin
        gls_new = (state_ff.gls[hit_cell] & ~be_mask)
                | (writedata & be_mask);
        nxt_state.gls[hit_cell] = gls_new;
      end else begin
        // Other bit positions are dropped  [RULE_12]
        if (byteenable[0]) begin
          nxt_state.src1_sel[hit_cell] =
            writedata[SRC1_LSB +: SEL_W];
        end
        if (byteenable[1]) begin
          nxt_state.src3_sel[hit_cell] =
            writedata[SRC3_LSB +: SEL_W];
        end
      end
    end
    // Gate matrix per cell
    for (int c = 0; c < CELL_COUNT; c++) begin
      for (int g = 0; g < GATE_COUNT; g++) begin
        // Pairs from source 4 at the top down to 1  [RULE_09]
        src_t[g*GATE_BYTE_W + 7] = source4_in[c];
        src_t[g*GATE_BYTE_W + 6] = ~source4_in[c];
        src_t[g*GATE_BYTE_W + 5] = pick3[c];
        src_t[g*GATE_BYTE_W + 4] = ~pick3[c];
        src_t[g*GATE_BYTE_W + 3] = source2_in[c];
        src_t[g*GATE_BYTE_W + 2] = ~source2_in[c];
        src_t[g*GATE_BYTE_W + 1] = pick1[c];
        src_t[g*GATE_BYTE_W + 0] = ~pick1[c];
      end
      // Enabled true and inverted forms pass  [RULE_10] [RULE_11]
      nxt_state.terms[c]        = src_t & state_ff.gls[c];
      nxt_state.sel_out.src1[c] = pick1[c];
      nxt_state.sel_out.src3[c] = pick3[c];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= '0;
      for (int c = 0; c < CELL_COUNT; c++) begin
        state_ff.src1_sel[c] <= SEL_RESET;
        state_ff.src3_sel[c] <= SEL_RESET;
        state_ff.gls[c]     <= GLS_RESET;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest = req & ~state_ff.ack;  // Held one cycle
  assign readdata    = state_ff.rdata;
  assign gate_terms  = state_ff.terms;
  assign selected    = state_ff.sel_out;

endmodule // cell_input_select

// >>> verification/cell_sel_sva.sv
/*
  Checker: bus handshake, select read-back, reset, cell 1 terms.
  Assumes it is bound to the stage's top module.
*/
`timescale 1ns/100ps
module cell_sel_sva
  import cell_sel_pkg::*;
#(
  parameter int CELLS = CELL_COUNT
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic [ADDR_W-1:0]     address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [DATA_W-1:0]     readdata,
  input  wire logic                  waitrequest,
  input  wire logic [CELL_COUNT-1:0] source2_in,
  input  wire logic [CELL_COUNT-1:0] source4_in,
  input  wire gate_terms_t           gate_terms
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [31:0] t0; // Cell 1 gate terms
  assign t0 = gate_terms[0];
  // Request waiting, then its answer
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest; endsequence
  property p_one_wait; s_req |=> s_ans; endproperty
  property p_take; $rose(read || write) |-> waitrequest; endproperty
  property p_idle; !(read || write) |-> !waitrequest; endproperty
  property p_sel_zero;
    read && !waitrequest && !address[3] && !address[0]
      |-> (readdata & 32'hFFFF_F8F8) == 32'h0;
  endproperty
  property p_pair_excl; (t0 & (t0 >> 1) & 32'h5555_5555) == 32'h0;
  endproperty
  property p_true4;
    |{t0[31], t0[23], t0[15], t0[7]} |-> $past(source4_in[0]);
  endproperty
  property p_inv4;
    |{t0[30], t0[22], t0[14], t0[6]} |-> !$past(source4_in[0]);
  endproperty
  property p_true2;
    |{t0[27], t0[19], t0[11], t0[3]} |-> $past(source2_in[0]);
  endproperty
  property p_inv2;
    |{t0[26], t0[18], t0[10], t0[2]} |-> !$past(source2_in[0]);
  endproperty
  property p_rst_clear;
    $fell(srst) |-> gate_terms == '0 && readdata == '0;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("no answer after one wait");
  a_take: assert property (p_take) else $error("request not held off");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_sel_zero: assert property (p_sel_zero)
    else $error("unused select bits read nonzero");
  a_pair_excl: assert property (p_pair_excl)
    else $error("true and inverted term both high");
  a_true4: assert property (p_true4)
    else $error("source 4 true term wrong");
  a_inv4: assert property (p_inv4)
    else $error("source 4 inverted term wrong");
  a_true2: assert property (p_true2)
    else $error("source 2 true term wrong");
  a_inv2: assert property (p_inv2)
    else $error("source 2 inverted term wrong");
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset left terms or data");
endmodule // cell_sel_sva

bind cell_input_select cell_sel_sva #(.CELLS(CELLS)) u_sva (
  .clock(clock), .srst(srst), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .source2_in(source2_in), .source4_in(source4_in),
  .gate_terms(gate_terms));

// >>> verification/src_model.sv
/*
  Far-side model: peripheral and pin levels for the stage.
  Assumes the bench sets levels off the sampling edge.
*/
`timescale 1ns/100ps
module src_model
  import cell_sel_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [28:0] want,
  input  wire logic [7:0]  want24,
  output periph_in_t       periph_in,
  output logic [3:0]       cell_out,
  output logic [3:0]       source2_in,
  output logic [3:0]       source4_in
);
  logic [36:0] hold = '0; // Levels as launched
  // Launch commanded levels on the edge
  always @(posedge clock) begin
    hold <= {want24, want};
  end
  assign {source4_in, source2_in, cell_out, periph_in} = hold;
endmodule // src_model

// >>> verification/logic_cell_input_select_tb.sv
/*
  Self-checking bench for the cell input selection stage.
  Assumes the bound checker and the source model.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module logic_cell_input_select_tb
  import cell_sel_pkg::*;
;
  logic              clock, srst, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata, q;
  logic [3:0]        byteenable, cell_out, source2_in, source4_in;
  logic [28:0]       want;
  logic [7:0]        want24;
  periph_in_t        periph_in;
  gate_terms_t       gate_terms;
  selected_t         selected;
  int                mismatches, cmp_count;

  cell_input_select uut (.clock(clock), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .periph_in(periph_in),
    .cell_out(cell_out), .source2_in(source2_in),
    .source4_in(source4_in), .gate_terms(gate_terms),
    .selected(selected));
  src_model u_src (.clock(clock), .want(want), .want24(want24),
    .periph_in(periph_in), .cell_out(cell_out),
    .source2_in(source2_in), .source4_in(source4_in));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // One transfer, held until waitrequest is low at an edge
  task automatic bus(input logic wr, input int a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= 4'(a);
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) mismatches++;
  endtask
  // One-hot source for code k; reserved gives none
  function automatic logic [28:0] one_src(int c, int ds, int k);
    periph_in_t p;
    logic [3:0] co;
    p = '0;
    co = '0;
    case (k)
      0: p.cell_pin_input_b[c] = 1'b1;
      1: co[c ^ 1] = 1'b1;
      2: if (ds == 1) p.single_compare_out[c] = 1'b1;
         else p.comparator_one = 1'b1;
      3: if (c < 3 && ds == 1) p.serial_data_in[c] = 1'b1;
         else if (c < 3) p.uart_tx[c] = 1'b1;
      4: if (ds == 1) p.comparator_three = 1'b1;
         else p.adc_done = 1'b1;
      5: if (ds == 1) p.real_time_clock_event = 1'b1;
         else p.dma_irq[c % 2] = 1'b1;
      6: p.multi_compare_match[(c < 2) ? 0 : c - 1] = 1'b1;
      default: if (ds == 1 && c < 2) p.single_compare5_match = 1'b1;
               else if (ds == 1) p.single_compare7_match = 1'b1;
    endcase
    return {co, p};
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, a, 32'h0, 4'hF);
      `CHK("reset_word", 32'h0, q)
    end
    bus(1'b1, 0, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 0, 32'h0, 4'hF);
    `CHK("sel_unused", 32'h0000_0707, q)
    bus(1'b1, 0, 32'h0, 4'h2);
    bus(1'b0, 0, 32'h0, 4'hF);
    `CHK("sel_lane", 32'h0000_0007, q)
    bus(1'b1, 3, 32'hA5C3_0F96, 4'hF);
    bus(1'b0, 3, 32'h0, 4'hF);
    `CHK("gls_rw", 32'hA5C3_0F96, q)
    bus(1'b1, 9, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 9, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    $display("t_regs done");
  endtask
  // Every code of both selectors in every cell, both polarities
  task automatic t_codes();
    logic [28:0] v;
    logic [1:0]  ex;
    logic [1:0]  pr;
    int          ds;
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 2; d++) begin
        ds = d ? 3 : 1;
        bus(1'b1, 2 * c + 1, d ? 32'h30 : 32'h3, 4'hF);
        for (int k = 0; k < 8; k++) begin
          bus(1'b1, 2 * c, d ? 32'(k) << 8 : 32'(k), 4'hF);
          v = one_src(c, ds, k);
          for (int pol = 0; pol < 2; pol++) begin
            want <= pol ? ~v : v;
            ex = (pol == 0 && v != '0) ? 2'b10 : 2'b01;
            repeat (6) @(posedge clock);
            pr = d ? gate_terms[c][5:4] : gate_terms[c][1:0];
            `CHK("term", ex, pr)
            pr[0] = d ? selected.src3[c] : selected.src1[c];
            `CHK("selected", ex[1], pr[0])
          end
        end
      end
    end
    $display("t_codes done");
  endtask
  // Enable bytes against all four sources of cell 1
  task automatic t_gate();
    logic [31:0] ens [4];
    logic [31:0] ex;
    periph_in_t  p;
    logic [3:0]  v;
    ens = '{32'hFFFF_FFFF, 32'hA5C3_0F96, 32'h5A3C_F069, 32'h8000_0001};
    bus(1'b1, 0, 32'h0000_0100, 4'hF);
    for (int i = 0; i < 8; i++) begin
      v = i[0] ? 4'h5 : 4'hA;
      bus(1'b1, 1, ens[i / 2], 4'hF);
      bus(1'b0, 1, 32'h0, 4'hF);
      `CHK("gls_rd", ens[i / 2], q)
      p = '0;
      p.cell_pin_input_b[0] = v[0];
      want <= {2'b0, v[2], 1'b0, p};
      want24 <= {3'b0, v[3], 3'b0, v[1]};
      ex = '0;
      for (int j = 0; j < 16; j++) begin
        ex[2 * j + 1 -: 2] = {v[j % 4], ~v[j % 4]}
                           & ens[i / 2][2 * j + 1 -: 2];
      end
      repeat (6) @(posedge clock);
      `CHK("terms", ex, gate_terms[0])
    end
    $display("t_gate done");
  endtask
  // Reset in mid-run clears enables and terms
  task automatic t_reset();
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK("rst_terms", gate_terms_t'(0), gate_terms)
    bus(1'b0, 1, 32'h0, 4'hF);
    `CHK("rst_gls", 32'h0, q)
    $display("t_reset done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {read, write, address, writedata, byteenable} = '0;
    {want, want24, mismatches, cmp_count} = '0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_codes();
    t_gate();
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (8000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule // logic_cell_input_select_tb
